// ### abu_top.sv
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [R1] address match with breaks enabled raises a break request
// [R2] break forces the swi opcode; vector fffc, or fefc in monitor mode
// [R3] writing one to the active bit breaks before next instruction
// [R4] break on opcode address holds that instruction until routine ends
// [R5] break on operand address lets the instruction finish first
// [R6] return from interrupt in the routine ends the break state
// [R7] match sets active bit; reset or software zero clears it
// [R8] enable bit seven gates full sixteen-bit match; reset clears it
// [R9] high and low address byte registers, cleared on reset
// [R10] active bit cleared, same address: no rebreak on return; the code re-arms on a cleared active bit alone
// [R11] new address and cleared active bit allow repeated breaks
// [R12] timers halt while a break is in progress
// [R13] watchdog held off in break when test voltage is on reset pin
// [R14] wait flag shows wait exit by break; cleared by writing zero
// [R15] in break, status clears allowed only when clear enable is set
// [R16] comparator keeps working in wait mode and wakes the cpu
// [R17] debugger should aim break address at an opcode
// [R18] only fetch addresses compare; new address applies after the write
module abu_top
    import abu_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // cpu side, same clock
    input  wire logic [15:0] fetchAddr,
    input  wire logic        fetchValid,
    input  wire logic        fetchOpcode,
    input  wire logic        instrBoundary,
    input  wire logic        returnFromInterrupt,
    input  wire logic        cpuInWait,
    input  wire logic        monitorMode,
    // test voltage sense on the reset pin, asynchronous
    input  wire logic        testVoltageLevel,
    // to system integration logic
    output logic             breakRequest,
    output logic             forceSoftwareInterruptOpcode,
    output logic [15:0]      breakVector,
    output logic             waitWake,
    output logic             timerFreeze,
    output logic             watchdogHold,
    output logic             statusClearAllowed,
    output logic             breakState,
    output logic             irq
);
    // ****************************************************************
    // signals
    // ****************************************************************
    abu_state_t  state_reg;
    abu_state_t  state_next;
    logic [7:0]  addrHigh_reg;
    logic [7:0]  addrLow_reg;
    logic        enable_reg;
    logic        active_reg;
    logic        waitFlag_reg;
    logic        clearEnable_reg;
    logic        pendOperand_reg;
    logic        tvMeta_reg;
    logic        tvSync_reg;
    logic [ABU_IRQ_NUM-1:0] irqStatus_reg;
    logic [ABU_IRQ_NUM-1:0] irqMask_reg;
    logic [ABU_IRQ_NUM-1:0] irqEvent;
    logic        wrAccess;
    logic        rdAccess;
    logic        softBreak;
    logic        hitNow;
    logic        mapped;
    logic [7:0]  rdByte;
    abu_cmp_if   cmpLink();

    // ****************************************************************
    // apb decode
    // ****************************************************************
    // zero wait states: every access completes in its first access cycle
    assign pready   = 1'b1;
    assign wrAccess = psel && penable && pwrite;
    assign rdAccess = psel && penable && !pwrite;
    assign mapped   = (paddr == ABU_OFS_STATUS_CONTROL) || (paddr == ABU_OFS_ADDRESS_HIGH) ||
                      (paddr == ABU_OFS_ADDRESS_LOW) || (paddr == ABU_OFS_WAIT_STATUS) ||
                      (paddr == ABU_OFS_FLAG_CONTROL) || (paddr == ABU_OFS_IRQ_STATUS) ||
                      (paddr == ABU_OFS_IRQ_MASK);
    assign pslverr  = psel && penable && !mapped;
    // [R3] software break
    assign softBreak = wrAccess && (paddr == ABU_OFS_STATUS_CONTROL) &&
                       pwdata[ABU_BIT_ACTIVE] && !active_reg;

    // ****************************************************************
    // comparator
    // ****************************************************************
    // [R18] registered address, so a write applies from the next fetch on
    assign cmpLink.breakAddr = {addrHigh_reg, addrLow_reg};
    // [R8] enable gates the compare
    assign cmpLink.enable    = enable_reg;
    // [R10] a stale match does not retrigger while active is held; clearing it re-arms the same address
    // [R11] a fresh address plus a cleared active bit re-arms the compare
    assign hitNow = cmpLink.hit && (state_reg == ABU_IDLE) && !active_reg;

    abu_comparator u_cmp (
        .link       (cmpLink.cmp),
        .fetchAddr  (fetchAddr),
        .fetchValid (fetchValid)
    );

    // ****************************************************************
    // test voltage synchroniser
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tvMeta_reg <= 1'b0;
            tvSync_reg <= 1'b0;
        end else begin
            tvMeta_reg <= testVoltageLevel;
            tvSync_reg <= tvMeta_reg;
        end
    end

    // ****************************************************************
    // break sequencer
    // ****************************************************************
    // next state of the break sequence
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ABU_IDLE: begin
                // [R1] match raises request
                if (hitNow || softBreak)
                    state_next = ABU_REQ;
            end
            ABU_REQ: begin
                // [R5] wait for instruction boundary
                if (instrBoundary)
                    state_next = ABU_BREAK;
            end
            ABU_BREAK: begin
                // [R6] return ends break
                if (returnFromInterrupt)
                    state_next = ABU_IDLE;
            end
            default: state_next = ABU_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n)
            state_reg <= ABU_IDLE;
        else
            state_reg <= state_next;
    end

    // opcode hit takes effect at once, operand hit after the instruction
    always_ff @(posedge mclk) begin
        if (!rst_n)
            pendOperand_reg <= 1'b0;
        else if (state_reg == ABU_IDLE && (hitNow || softBreak))
            pendOperand_reg <= hitNow && !fetchOpcode;
    end

    // ****************************************************************
    // outputs to the system integration logic
    // ****************************************************************
    // [R1] request level while pending
    assign breakRequest = (state_reg == ABU_REQ);
    // [R2] swi injection; [R4] opcode hit replaces the opcode itself
    assign forceSoftwareInterruptOpcode = (state_reg == ABU_REQ) &&
                                          (instrBoundary || !pendOperand_reg);
    // [R2] vector selection
    assign breakVector = monitorMode ? ABU_VEC_MONITOR : ABU_VEC_NORMAL;
    assign breakState  = (state_reg == ABU_BREAK);
    // [R16] wake the cpu out of wait
    assign waitWake    = breakRequest && cpuInWait;
    // [R12] timer freeze
    assign timerFreeze = (state_reg != ABU_IDLE);
    // [R13] watchdog hold
    assign watchdogHold = breakState && tvSync_reg;
    // [R15] clear protection
    assign statusClearAllowed = !breakState || clearEnable_reg;

    // ****************************************************************
    // registers
    // ****************************************************************
    // [R9] break address bytes
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            addrHigh_reg <= ABU_RST_BYTE;
            addrLow_reg  <= ABU_RST_BYTE;
        end else if (wrAccess && paddr == ABU_OFS_ADDRESS_HIGH) begin
            addrHigh_reg <= pwdata[7:0];
        end else if (wrAccess && paddr == ABU_OFS_ADDRESS_LOW) begin
            addrLow_reg <= pwdata[7:0];
        end
    end

    // [R8] enable bit, cleared on reset
    always_ff @(posedge mclk) begin
        if (!rst_n)
            enable_reg <= 1'b0;
        else if (wrAccess && paddr == ABU_OFS_STATUS_CONTROL)
            enable_reg <= pwdata[ABU_BIT_ENABLE];
    end

    // [R7] active bit: hardware set wins over software clear
    always_ff @(posedge mclk) begin
        if (!rst_n)
            active_reg <= 1'b0;
        else if (hitNow)
            active_reg <= 1'b1;
        else if (wrAccess && paddr == ABU_OFS_STATUS_CONTROL)
            active_reg <= pwdata[ABU_BIT_ACTIVE];
    end

    // [R14] wait exit flag; a set in the clearing cycle wins
    always_ff @(posedge mclk) begin
        if (!rst_n)
            waitFlag_reg <= 1'b0;
        else if (waitWake)
            waitFlag_reg <= 1'b1;
        else if (wrAccess && paddr == ABU_OFS_WAIT_STATUS && !pwdata[ABU_BIT_WAIT_FLAG])
            waitFlag_reg <= 1'b0;
    end

    // [R15] clear enable bit
    always_ff @(posedge mclk) begin
        if (!rst_n)
            clearEnable_reg <= 1'b0;
        else if (wrAccess && paddr == ABU_OFS_FLAG_CONTROL)
            clearEnable_reg <= pwdata[ABU_BIT_CLEAR_ENABLE];
    end

    // ****************************************************************
    // interrupt status and mask
    // ****************************************************************
    assign irqEvent[ABU_IRQ_HIT]    = hitNow;
    assign irqEvent[ABU_IRQ_SOFT]   = softBreak;
    assign irqEvent[ABU_IRQ_WAKE]   = waitWake && !waitFlag_reg;
    assign irqEvent[ABU_IRQ_RETURN] = breakState && returnFromInterrupt;

    // sticky bits, write one to clear, event wins over clear
    generate
        for (genvar i = 0; i < ABU_IRQ_NUM; i++) begin : g_irq
            always_ff @(posedge mclk) begin
                if (!rst_n)
                    irqStatus_reg[i] <= 1'b0;
                else if (irqEvent[i])
                    irqStatus_reg[i] <= 1'b1;
                else if (wrAccess && paddr == ABU_OFS_IRQ_STATUS && pwdata[i])
                    irqStatus_reg[i] <= 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (!rst_n)
            irqMask_reg <= '0;
        else if (wrAccess && paddr == ABU_OFS_IRQ_MASK)
            irqMask_reg <= pwdata[ABU_IRQ_NUM-1:0];
    end

    assign irq = |(irqStatus_reg & irqMask_reg);

    // ****************************************************************
    // read mux
    // ****************************************************************
    always_comb begin
        rdByte = ABU_RST_BYTE;
        case (paddr)
            ABU_OFS_STATUS_CONTROL: begin
                rdByte[ABU_BIT_ENABLE] = enable_reg;
                rdByte[ABU_BIT_ACTIVE] = active_reg;
            end
            ABU_OFS_ADDRESS_HIGH: rdByte = addrHigh_reg;
            ABU_OFS_ADDRESS_LOW:  rdByte = addrLow_reg;
            ABU_OFS_WAIT_STATUS:  rdByte[ABU_BIT_WAIT_FLAG] = waitFlag_reg;
            ABU_OFS_FLAG_CONTROL: rdByte[ABU_BIT_CLEAR_ENABLE] = clearEnable_reg;
            ABU_OFS_IRQ_STATUS:   rdByte[ABU_IRQ_NUM-1:0] = irqStatus_reg;
            ABU_OFS_IRQ_MASK:     rdByte[ABU_IRQ_NUM-1:0] = irqMask_reg;
            default:              rdByte = ABU_RST_BYTE;
        endcase
    end

    // read data held in a flop, loaded in the setup cycle
    always_ff @(posedge mclk) begin
        if (!rst_n)
            prdata <= '0;
        else if (psel && !penable && !pwrite)
            prdata <= {24'h000000, rdByte};
    end
endmodule : abu_top
`default_nettype wire

// ### abu_pkg.sv
package abu_pkg;
    // register byte addresses on the apb window
    localparam logic [7:0] ABU_OFS_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] ABU_OFS_ADDRESS_HIGH   = 8'h04;
    localparam logic [7:0] ABU_OFS_ADDRESS_LOW    = 8'h08;
    localparam logic [7:0] ABU_OFS_WAIT_STATUS    = 8'h0C;
    localparam logic [7:0] ABU_OFS_FLAG_CONTROL   = 8'h10;
    localparam logic [7:0] ABU_OFS_IRQ_STATUS     = 8'h14;
    localparam logic [7:0] ABU_OFS_IRQ_MASK       = 8'h18;
    // field positions
    localparam int ABU_BIT_ENABLE       = 7;
    localparam int ABU_BIT_ACTIVE       = 6;
    localparam int ABU_BIT_WAIT_FLAG    = 1;
    localparam int ABU_BIT_CLEAR_ENABLE = 7;
    // interrupt status bits
    localparam int ABU_IRQ_HIT    = 0;
    localparam int ABU_IRQ_SOFT   = 1;
    localparam int ABU_IRQ_WAKE   = 2;
    localparam int ABU_IRQ_RETURN = 3;
    localparam int ABU_IRQ_NUM    = 4;
    // reset values
    localparam logic [7:0]  ABU_RST_BYTE = 8'h00;
    localparam logic [15:0] ABU_RST_ADDR = 16'h0000;
    // break vectors
    localparam logic [15:0] ABU_VEC_NORMAL  = 16'hFFFC;
    localparam logic [15:0] ABU_VEC_MONITOR = 16'hFEFC;
    // break sequencer states, one-hot
    typedef enum logic [2:0] {
        ABU_IDLE   = 3'b001,
        ABU_REQ    = 3'b010,
        ABU_BREAK  = 3'b100
    } abu_state_t;
endpackage : abu_pkg

// ### abu_cmp_if.sv
`timescale 1ns/1ps
`default_nettype none
// link between the register file and the address comparator
interface abu_cmp_if;
    logic [15:0] breakAddr;
    logic        enable;
    logic        hit;
    modport regs (output breakAddr, output enable, input hit);
    modport cmp  (input breakAddr, input enable, output hit);
endinterface : abu_cmp_if
`default_nettype wire

// ### abu_comparator.sv
`timescale 1ns/1ps
`default_nettype none
module abu_comparator
    import abu_pkg::*;
(
    abu_cmp_if.cmp           link,
    input  wire logic [15:0] fetchAddr,
    input  wire logic        fetchValid
);
    // only program fetches take part; opcode or operand fetch both match
    assign link.hit = link.enable && fetchValid && (fetchAddr == link.breakAddr);
endmodule : abu_comparator
`default_nettype wire

// ### abu_chk.sv
`timescale 1ns/1ps
`default_nettype none
// *****************************
// break unit port checker
// *****************************
module abu_chk (
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        instrBoundary,
    input wire logic        returnFromInterrupt,
    input wire logic        cpuInWait,
    input wire logic        monitorMode,
    input wire logic        breakRequest,
    input wire logic        forceSoftwareInterruptOpcode,
    input wire logic [15:0] breakVector,
    input wire logic        waitWake,
    input wire logic        timerFreeze,
    input wire logic        watchdogHold,
    input wire logic        statusClearAllowed,
    input wire logic        breakState
);
    // single domain, so one clocking and one reset guard
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    // a pending request must outlive the current instruction
    AST_REQ_HOLDS: assert property (breakRequest && !instrBoundary |=> breakRequest)
        else $error("request dropped early");
    AST_REQ_TO_BREAK: assert property (breakRequest && instrBoundary
        |-> forceSoftwareInterruptOpcode ##1 (breakState && !breakRequest))
        else $error("boundary did not start break");
    AST_VECTOR: assert property (breakRequest
        |-> breakVector == (monitorMode ? 16'hFEFC : 16'hFFFC))
        else $error("wrong break vector");
    AST_RTI_ENDS: assert property (breakState && returnFromInterrupt |=> !timerFreeze)
        else $error("return did not end break");
    AST_TIMERS: assert property (timerFreeze == (breakRequest || breakState))
        else $error("timer freeze wrong");
    AST_WAKE: assert property (waitWake == (breakRequest && cpuInWait))
        else $error("wake wrong");
    AST_WATCHDOG: assert property (watchdogHold |-> breakState)
        else $error("watchdog held outside break");
    AST_CLEAR_GATE: assert property (!breakState |-> statusClearAllowed)
        else $error("clear blocked outside break");
endmodule : abu_chk
bind abu_top abu_chk chk (.mclk, .rst_n, .instrBoundary, .returnFromInterrupt, .cpuInWait,
    .monitorMode, .breakRequest, .forceSoftwareInterruptOpcode, .breakVector, .waitWake,
    .timerFreeze, .watchdogHold, .statusClearAllowed, .breakState);
`default_nettype wire

// ### abu_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// *****************************
// cpu fetch model
// *****************************
module abu_cpu_model (
    input  wire logic  mclk,
    input  wire logic  rst_n,
    input  wire logic  slow,
    input  wire logic  leave,
    input  wire logic  breakRequest,
    input  wire logic  breakState,
    output logic [15:0] fetchAddr = 16'h0000,
    output logic        fetchValid = 1'b0,
    output logic        fetchOpcode = 1'b0,
    output logic        instrBoundary = 1'b0,
    output logic        returnFromInterrupt = 1'b0
);
    logic [7:0] pcReg = 8'h00;
    logic [1:0] phaseReg = 2'h0;
    always @(posedge mclk) begin
        fetchValid <= 1'b0;
        instrBoundary <= 1'b0;
        fetchAddr <= ~fetchAddr; // idle bus must not repeat a stale address
        if (!rst_n || breakState) begin
            phaseReg <= 2'h0;
        end else if (phaseReg == 2'h0) begin
            fetchValid <= 1'b1;
            fetchOpcode <= 1'b1;
            fetchAddr <= {8'h01, pcReg};
            phaseReg <= 2'h1;
        end else if (phaseReg == 2'h1) begin
            fetchValid <= 1'b1;
            fetchOpcode <= 1'b0;
            fetchAddr <= {8'h01, pcReg + 8'h01};
            instrBoundary <= 1'b1;
            pcReg <= pcReg + 8'h02;
            phaseReg <= slow ? 2'h2 : 2'h0;
        end else begin
            phaseReg <= 2'h0;
        end
    end
    always @(posedge mclk) begin
        returnFromInterrupt <= rst_n && breakState && leave && !returnFromInterrupt;
    end
endmodule : abu_cpu_model
`default_nettype wire

// ### abu_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module abu_top_tb;
    import abu_pkg::*;
    logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, perr, irq, slow, leave;
    logic        fetchValid, fetchOpcode, instrBoundary, returnFromInterrupt, cpuInWait;
    logic        monitorMode, testVoltageLevel, breakRequest, forceSoftwareInterruptOpcode;
    logic        waitWake, timerFreeze, watchdogHold, statusClearAllowed, breakState;
    logic [7:0]  paddr;
    logic [15:0] fetchAddr, breakVector;
    logic [31:0] pwdata, prdata, rdata;
    int          num_errors, num_checks, adr, cnt, mdl[7];
    abu_top dut (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .fetchAddr, .fetchValid, .fetchOpcode, .instrBoundary, .returnFromInterrupt,
        .cpuInWait, .monitorMode, .testVoltageLevel, .breakRequest, .breakVector,
        .forceSoftwareInterruptOpcode, .waitWake, .timerFreeze, .watchdogHold,
        .statusClearAllowed, .breakState, .irq);
    abu_cpu_model cpu (.mclk, .rst_n, .slow, .leave, .breakRequest, .breakState, .fetchAddr,
        .fetchValid, .fetchOpcode, .instrBoundary, .returnFromInterrupt);
    // *****************************
    // bench tasks
    // *****************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    // request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rdata = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // writes keep the bench register copy in step; the irq status clears on one
    task automatic wr(input int i, input int d);
        apb(1'b1, 8'(i * 4), 32'(d));
        mdl[i] = (i == 5) ? mdl[i] & ~d : d;
    endtask : wr
    task automatic rd(input int i);
        apb(1'b0, 8'(i * 4), 32'h0);
        check(rdata, 32'(mdl[i]));
    endtask : rd
    // polled at the falling edge so outputs have settled
    task automatic waitOn(input logic st, input logic lvl);
        cnt = 0;
        do begin
            @(negedge mclk);
            cnt++;
        end while ((st ? breakState : breakRequest) !== lvl && cnt < 2000);
        check(32'(cnt < 2000), 32'h1);
    endtask : waitOn
    task automatic endBreak();
        @(posedge mclk);
        leave <= 1'b1;
        waitOn(1'b1, 1'b0);
        @(posedge mclk);
        leave <= 1'b0;
        mdl[5] |= 8;
    endtask : endBreak
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // hang guard, several times the expected run
    initial begin
        #100000;
        num_errors++;
        conclude();
    end
    initial begin
        {rst_n, psel, penable, pwrite, paddr, pwdata, cpuInWait} = '0;
        {monitorMode, testVoltageLevel, slow, leave, num_errors, num_checks} = '0;
        mdl = '{default: 0};
        void'($urandom(73));
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        for (int i = 0; i < 7; i++) rd(i);
        apb(1'b0, 8'h1C, 32'h0);
        check({rdata[31:1], perr}, 32'h1);
        $display("test registers done");
        wr(6, 8'h0F);
        for (int k = 0; k < 4; k++) begin
            adr = 16'h0100 | ($urandom % 256);
            wr(4, 8'h80);
            wr(1, adr >> 8);
            wr(2, adr & 255);
            slow <= k[0];
            monitorMode <= k > 1;
            testVoltageLevel <= k == 2;
            cpuInWait <= k == 3;
            wr(0, 8'h80);
            if (k > 0) endBreak();
            waitOn(1'b0, 1'b1);
            check(32'(breakVector), k > 1 ? ABU_VEC_MONITOR : ABU_VEC_NORMAL);
            check(32'({timerFreeze, waitWake, irq}), 32'({1'b1, k == 3, 1'b1}));
            mdl[0] = 8'hC0;
            mdl[3] = (k == 3) ? 2 : 0;
            mdl[5] |= (k == 3) ? 5 : 1;
            waitOn(1'b1, 1'b1);
            wr(4, k[0] ? 8'h80 : 8'h00);
            @(negedge mclk);
            check(32'({watchdogHold, statusClearAllowed}), 32'({k == 2, k[0]}));
            rd(0);
            rd(3);
            if (k == 3) wr(3, 0);
            rd(3);
            $display("test break %0d done", k);
        end
        // leave wait so later breaks raise no wake event
        cpuInWait <= 1'b0;
        wr(0, 0);
        endBreak();
        cnt = 0;
        repeat (500) begin
            @(negedge mclk);
            if (breakRequest !== 1'b0) cnt++;
        end
        check(32'(cnt), 32'h0);
        rd(5);
        wr(5, 8'h0F);
        wr(6, 8'h05);
        @(negedge mclk);
        check(32'(irq), 32'h0);
        $display("test disable done");
        wr(0, 8'h40);
        @(negedge mclk);
        check(32'({breakRequest, irq}), 32'h2);
        mdl[5] = 2;
        waitOn(1'b1, 1'b1);
        wr(0, 0);
        endBreak();
        rd(5);
        check(32'(irq), 32'h0);
        $display("test soft done");
        conclude();
    end
endmodule : abu_top_tb
`default_nettype wire
